// [pkg/opmode_defs.svh]
`ifndef OPMODE_DEFS_SVH
`define OPMODE_DEFS_SVH

// ============================================================
// Operation mode select setting values
`define SEL_EXT_PANEL   3'h0
`define SEL_PANEL_ONLY  3'h1
`define SEL_EXT_ONLY    3'h2
`define SEL_COMBINED1   3'h3
`define SEL_COMBINED2   3'h4
`define SEL_SWITCHOVER  3'h6
`define SEL_INTERLOCK   3'h7
`define SEL_RESET       3'h0

// ============================================================
// Widths and reset values
`define FREQ_W          16
`define FREQ_RESET      16'h0000

`endif

// [pkg/opmode_pkg.sv]
`include "opmode_defs.svh"

package opmode_pkg;

    // ============================================================
    // Types
    typedef enum logic [2:0] {
        MODE_EXTERNAL,
        MODE_PANEL_UNIT,
        MODE_NETWORK,
        MODE_COMBINED1,
        MODE_COMBINED2
    } mode_t;

    typedef struct packed {
        logic forward_start_input;
        logic reverse_start_input;
        logic terminal4_select_input;
        logic inching_speed_input;
        logic multi_speed_input;
        logic panel_interlock_input;
        logic output_stop_input;
        logic key_run_fwd;
        logic key_run_rev;
        logic key_stop;
        logic key_panel_unit;
        logic key_external;
    } term_pins_t;

    typedef struct packed {
        logic [`FREQ_W-1:0] analog2;
        logic [`FREQ_W-1:0] analog4;
        logic [`FREQ_W-1:0] multi;
        logic [`FREQ_W-1:0] inching;
    } freq_in_t;

    typedef struct packed {
        logic               to_network;
        logic               to_external;
        logic               set_run;
        logic               run_fwd;
        logic               run_rev;
        logic               set_freq;
        logic [`FREQ_W-1:0] freq;
    } net_cmd_t;

endpackage : opmode_pkg

// [rtl/drive_operation_mode_select.sv]
`timescale 1ns/10ps
`include "opmode_defs.svh"

module drive_operation_mode_select (
    input  wire logic                   i_clk,
    input  wire logic                   i_srst,
    input  wire opmode_pkg::term_pins_t i_pins,
    input  wire opmode_pkg::freq_in_t   i_freq_ext,
    input  wire logic [`FREQ_W-1:0]     i_panel_freq,
    input  wire logic                   i_panel_freq_wr,
    input  wire logic                   i_net_cmd_valid,
    input  wire opmode_pkg::net_cmd_t   i_net_cmd,
    input  wire logic                   i_motor_running,
    input  wire logic [2:0]             i_mode_sel_init,
    input  wire logic                   i_interlock_assigned,
    input  wire logic                   i_ostop_assigned,
    input  wire logic                   i_stop_key_all,
    input  wire logic                   i_param_wr,
    input  wire logic                   i_param_is_mode_sel,
    input  wire logic [2:0]             i_param_data,
    input  wire logic                   i_param_ext_writable,
    input  wire logic                   i_param_write_enabled,
    output opmode_pkg::mode_t           o_mode,
    output logic [2:0]                  o_mode_sel,
    output logic                        o_run_fwd,
    output logic                        o_run_rev,
    output logic [`FREQ_W-1:0]          o_freq_cmd,
    output logic                        o_output_stop,
    output logic                        o_param_wr_ok,
    output logic                        o_param_wr_rej,
    output logic                        o_switch_refused
);
    import opmode_pkg::*;

    localparam int PIN_W = $bits(term_pins_t);

    // ============================================================
    // Pin filtering
    logic [PIN_W-1:0] s1_r;
    logic [PIN_W-1:0] s2_r;
    logic [PIN_W-1:0] s3_r;
    logic [PIN_W-1:0] flt_r;
    term_pins_t       pin;
    term_pins_t       pin_prev_r;

    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
        end
        else
        begin
            s1_r <= i_pins;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // A level counts only once two successive samples agree, which rejects contact bounce.
    for (genvar b = 0; b < PIN_W; b++)
    begin : g_filter
        always_ff @(posedge i_clk)
        begin
            if (i_srst)
                flt_r[b] <= 1'b0;
            else if (s2_r[b] == s3_r[b])
                flt_r[b] <= s3_r[b];
        end
    end

    assign pin = flt_r;

    always_ff @(posedge i_clk)
    begin
        if (i_srst)
            pin_prev_r <= '0;
        else
            pin_prev_r <= pin;
    end

    // ============================================================
    // State and requests
    mode_t              mode_r;
    mode_t              mode_nxt;
    logic [2:0]         sel_r;
    logic               init_r;
    logic               il;
    logic               il_prev_r;
    logic               il_fall;
    logic               stopped;
    logic               req_panel;
    logic               req_ext;
    logic               req_net;
    logic               req_net_ext;
    logic               refused;
    logic               wr_ok;
    logic               sel_wr;
    logic               stop_hold_r;
    logic [`FREQ_W-1:0] pu_freq_r;
    logic               pu_fwd_r;
    logic               pu_rev_r;
    logic [`FREQ_W-1:0] net_freq_r;
    logic               net_fwd_r;
    logic               net_rev_r;
    logic [`FREQ_W-1:0] ext_freq;
    logic [`FREQ_W-1:0] freq_nxt;
    logic               fwd_nxt;
    logic               rev_nxt;

    function automatic mode_t start_mode(input logic [2:0] sel);
        case (sel)
            `SEL_PANEL_ONLY: start_mode = MODE_PANEL_UNIT;
            `SEL_COMBINED1:  start_mode = MODE_COMBINED1;
            `SEL_COMBINED2:  start_mode = MODE_COMBINED2;
            default:         start_mode = MODE_EXTERNAL;
        endcase
    endfunction : start_mode

    function automatic logic path_ok(input logic [2:0] sel, input logic ilk, input mode_t f, input mode_t t);
        case (sel)
            `SEL_EXT_PANEL, `SEL_SWITCHOVER: path_ok = 1'b1;
            `SEL_EXT_ONLY:  path_ok = (t != MODE_PANEL_UNIT) && (f != MODE_PANEL_UNIT);
            `SEL_INTERLOCK: path_ok = ilk || ((f != MODE_EXTERNAL) && (t != MODE_EXTERNAL));
            default:        path_ok = 1'b0;
        endcase
    endfunction : path_ok

    // The output-stop input stands in for an unassigned interlock terminal.
    assign il = i_interlock_assigned ? pin.panel_interlock_input :
                i_ostop_assigned ? pin.output_stop_input : 1'b1;
    assign il_fall = il_prev_r && !il;
    assign stopped = !i_motor_running;
    assign req_ext = pin.key_external && !pin_prev_r.key_external && (mode_r == MODE_PANEL_UNIT);
    assign req_panel = pin.key_panel_unit && !pin_prev_r.key_panel_unit &&
                       ((mode_r == MODE_EXTERNAL) || (mode_r == MODE_NETWORK));
    assign req_net = i_net_cmd_valid && i_net_cmd.to_network &&
                     ((mode_r == MODE_EXTERNAL) || (mode_r == MODE_PANEL_UNIT));
    assign req_net_ext = i_net_cmd_valid && i_net_cmd.to_external && (mode_r == MODE_NETWORK);

    // Writes of the mode select setting are a parameter write too.
    always_comb
    begin
        if (i_param_is_mode_sel)
            wr_ok = stopped;
        else if ((sel_r == `SEL_INTERLOCK) && !il)
            wr_ok = 1'b0;
        else
            wr_ok = i_param_write_enabled && ((mode_r != MODE_EXTERNAL) || i_param_ext_writable);
    end

    assign sel_wr = i_param_wr && i_param_is_mode_sel && wr_ok;

    // ============================================================
    // Mode transitions
    always_comb
    begin
        mode_t t;
        t = mode_r;
        mode_nxt = mode_r;
        refused = 1'b0;
        if (req_ext)
            t = MODE_EXTERNAL;
        else if (req_panel)
            t = MODE_PANEL_UNIT;
        else if (req_net)
            t = MODE_NETWORK;
        else if (req_net_ext)
            t = MODE_EXTERNAL;
        if (init_r)
            mode_nxt = start_mode(i_mode_sel_init);
        else if (sel_wr)
            mode_nxt = start_mode(i_param_data);
        else if ((sel_r == `SEL_INTERLOCK) && il_fall)
            mode_nxt = MODE_EXTERNAL;
        else if (t != mode_r)
        begin
            // Only switchover lets a requested switch go through under a running motor.
            if (path_ok(sel_r, il, mode_r, t) && (stopped || (sel_r == `SEL_SWITCHOVER)))
                mode_nxt = t;
            else
                refused = 1'b1;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            mode_r <= MODE_EXTERNAL;
            sel_r <= `SEL_RESET;
            init_r <= 1'b1;
            il_prev_r <= 1'b1;
        end
        else
        begin
            mode_r <= mode_nxt;
            init_r <= 1'b0;
            il_prev_r <= il;
            if (init_r)
                sel_r <= i_mode_sel_init;
            else if (sel_wr)
                sel_r <= i_param_data;
        end
    end

    // ============================================================
    // Held commands
    // Entering panel-unit or network mode copies the command in force, so the motor carries on.
    // These copies live only in flip-flops and vanish at reset.
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            pu_freq_r <= `FREQ_RESET;
            pu_fwd_r <= 1'b0;
            pu_rev_r <= 1'b0;
        end
        else if ((mode_nxt == MODE_PANEL_UNIT) && (mode_r != MODE_PANEL_UNIT))
        begin
            pu_freq_r <= o_freq_cmd;
            pu_fwd_r <= o_run_fwd;
            pu_rev_r <= o_run_rev;
        end
        else
        begin
            if (i_panel_freq_wr)
                pu_freq_r <= i_panel_freq;
            if (pin.key_stop && !pin_prev_r.key_stop)
            begin
                pu_fwd_r <= 1'b0;
                pu_rev_r <= 1'b0;
            end
            else if (pin.key_run_fwd && !pin_prev_r.key_run_fwd)
            begin
                pu_fwd_r <= 1'b1;
                pu_rev_r <= 1'b0;
            end
            else if (pin.key_run_rev && !pin_prev_r.key_run_rev)
            begin
                pu_fwd_r <= 1'b0;
                pu_rev_r <= 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            net_freq_r <= `FREQ_RESET;
            net_fwd_r <= 1'b0;
            net_rev_r <= 1'b0;
        end
        else if ((mode_nxt == MODE_NETWORK) && (mode_r != MODE_NETWORK))
        begin
            net_freq_r <= o_freq_cmd;
            net_fwd_r <= o_run_fwd;
            net_rev_r <= o_run_rev;
        end
        else if (i_net_cmd_valid && (mode_r == MODE_NETWORK))
        begin
            if (i_net_cmd.set_freq)
                net_freq_r <= i_net_cmd.freq;
            if (i_net_cmd.set_run)
            begin
                net_fwd_r <= i_net_cmd.run_fwd && !i_net_cmd.run_rev;
                net_rev_r <= i_net_cmd.run_rev && !i_net_cmd.run_fwd;
            end
        end
    end

    // ============================================================
    // Command sources
    always_comb
    begin
        if (pin.terminal4_select_input)
            ext_freq = i_freq_ext.analog4;
        else if (pin.multi_speed_input)
            ext_freq = i_freq_ext.multi;
        else if (pin.inching_speed_input)
            ext_freq = i_freq_ext.inching;
        else
            ext_freq = i_freq_ext.analog2;
    end

    always_comb
    begin
        freq_nxt = ext_freq;
        fwd_nxt = pin.forward_start_input && !pin.reverse_start_input;
        rev_nxt = pin.reverse_start_input && !pin.forward_start_input;
        case (mode_r)
            MODE_PANEL_UNIT:
            begin
                freq_nxt = pu_freq_r;
                fwd_nxt = pu_fwd_r;
                rev_nxt = pu_rev_r;
            end
            MODE_NETWORK:
            begin
                freq_nxt = net_freq_r;
                fwd_nxt = net_fwd_r;
                rev_nxt = net_rev_r;
            end
            MODE_COMBINED1:
            begin
                if (pin.multi_speed_input)
                    freq_nxt = i_freq_ext.multi;
                else if (pin.terminal4_select_input)
                    freq_nxt = i_freq_ext.analog4;
                else
                    freq_nxt = pu_freq_r;
            end
            MODE_COMBINED2:
            begin
                fwd_nxt = pu_fwd_r;
                rev_nxt = pu_rev_r;
            end
            default:
            begin
                freq_nxt = ext_freq;
            end
        endcase
    end

    // The stop key outside panel-unit mode holds the motor until every start source is released.
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
            stop_hold_r <= 1'b0;
        else if (i_stop_key_all && pin.key_stop && !pin_prev_r.key_stop && (mode_r != MODE_PANEL_UNIT))
            stop_hold_r <= 1'b1;
        else if (!fwd_nxt && !rev_nxt)
            stop_hold_r <= 1'b0;
    end

    // ============================================================
    // Outputs
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            o_freq_cmd <= `FREQ_RESET;
            o_run_fwd <= 1'b0;
            o_run_rev <= 1'b0;
            o_output_stop <= 1'b0;
            o_param_wr_ok <= 1'b0;
            o_param_wr_rej <= 1'b0;
            o_switch_refused <= 1'b0;
        end
        else
        begin
            o_freq_cmd <= freq_nxt;
            o_run_fwd <= fwd_nxt && !stop_hold_r;
            o_run_rev <= rev_nxt && !stop_hold_r;
            o_output_stop <= ((sel_r == `SEL_INTERLOCK) && il && (mode_r == MODE_EXTERNAL)) ||
                             (i_ostop_assigned && pin.output_stop_input &&
                              !((sel_r == `SEL_INTERLOCK) && !i_interlock_assigned));
            o_param_wr_ok <= i_param_wr && wr_ok;
            o_param_wr_rej <= i_param_wr && !wr_ok;
            o_switch_refused <= refused;
        end
    end

    assign o_mode = mode_r;
    assign o_mode_sel = sel_r;

    // ============================================================
    // Checks
    sequence s_ext_to_panel;
        (mode_r == MODE_EXTERNAL) ##1 (mode_r == MODE_PANEL_UNIT);
    endsequence

    sequence s_to_network;
        (mode_r != MODE_NETWORK) ##1 (mode_r == MODE_NETWORK);
    endsequence

    chk_init_external: assert property (@(posedge i_clk) disable iff (i_srst)
        init_r && ((i_mode_sel_init == `SEL_EXT_PANEL) || (i_mode_sel_init == `SEL_EXT_ONLY))
        |=> (mode_r == MODE_EXTERNAL)) else $error("power-on mode is not External");
    chk_locked_external: assert property (@(posedge i_clk) disable iff (i_srst)
        !init_r && !sel_wr && (sel_r == `SEL_EXT_ONLY) |=> (mode_r != MODE_PANEL_UNIT))
        else $error("setting 2 reached panel-unit mode");
    chk_key_to_panel: assert property (@(posedge i_clk) disable iff (i_srst)
        !init_r && !sel_wr && (sel_r == `SEL_EXT_PANEL) && req_panel && stopped && (mode_r == MODE_EXTERNAL)
        |=> (mode_r == MODE_PANEL_UNIT)) else $error("panel key did not switch mode");
    chk_ext_write_block: assert property (@(posedge i_clk) disable iff (i_srst)
        i_param_wr && !i_param_is_mode_sel && (mode_r == MODE_EXTERNAL) && !i_param_ext_writable
        |=> !o_param_wr_ok && o_param_wr_rej) else $error("write accepted in External mode");
    chk_panel_fixed: assert property (@(posedge i_clk) disable iff (i_srst)
        (!init_r && (sel_r == `SEL_PANEL_ONLY)) ##1 (sel_r == `SEL_PANEL_ONLY) |-> (mode_r == MODE_PANEL_UNIT))
        else $error("setting 1 left panel-unit mode");
    chk_multi_priority: assert property (@(posedge i_clk) disable iff (i_srst)
        (mode_r == MODE_COMBINED1) && pin.multi_speed_input |=> (o_freq_cmd == $past(i_freq_ext.multi)))
        else $error("multi-speed did not win in combined mode 1");
    chk_carry_panel: assert property (@(posedge i_clk) disable iff (i_srst)
        s_ext_to_panel |-> (pu_freq_r == $past(o_freq_cmd)) && (pu_fwd_r == $past(o_run_fwd)))
        else $error("frequency not kept entering panel-unit mode");
    chk_carry_network: assert property (@(posedge i_clk) disable iff (i_srst)
        s_to_network |-> (net_freq_r == $past(o_freq_cmd)) && (net_rev_r == $past(o_run_rev)))
        else $error("command not kept entering network mode");
    chk_interlock_force: assert property (@(posedge i_clk) disable iff (i_srst)
        !init_r && !sel_wr && (sel_r == `SEL_INTERLOCK) && il_fall |=> (mode_r == MODE_EXTERNAL))
        else $error("interlock off did not force External mode");
    chk_sel_while_run: assert property (@(posedge i_clk) disable iff (i_srst)
        !init_r && i_param_wr && i_param_is_mode_sel && i_motor_running |=> !o_param_wr_ok && $stable(sel_r))
        else $error("mode select changed while running");
    chk_interlock_write: assert property (@(posedge i_clk) disable iff (i_srst)
        i_param_wr && !i_param_is_mode_sel && (sel_r == `SEL_INTERLOCK) && !il |=> o_param_wr_rej)
        else $error("write accepted with interlock off");

endmodule : drive_operation_mode_select

// [tb/net_master_model.sv]
`timescale 1ns/10ps

// ============================================================
// Network master and terminal assignment seen by the drive.
module net_master_model (
    input  wire logic          i_clk,
    output logic               o_valid,
    output opmode_pkg::net_cmd_t o_cmd,
    output logic               o_interlock_assigned,
    output logic               o_ostop_assigned
);
    import opmode_pkg::*;

    // The interlock starts on its own terminal, so output stop keeps its normal role.
    initial
    begin
        o_valid              = 1'b0;
        o_cmd                = '0;
        o_interlock_assigned = 1'b1;
        o_ostop_assigned     = 1'b1;
    end

    // Taking the interlock function off its terminal leaves output stop to stand in for it.
    task automatic assign_terminals(input logic il_term, input logic os_term);
        @(posedge i_clk);
        o_interlock_assigned <= il_term;
        o_ostop_assigned     <= os_term;
    endtask : assign_terminals

    // A released command bus shows the inverse of its last value, never a stale copy.
    task automatic send(input logic to_net, input logic to_ext);
        @(posedge i_clk);
        o_valid <= 1'b1;
        o_cmd   <= '{to_network: to_net, to_external: to_ext, default: '0};
        @(posedge i_clk);
        o_valid <= 1'b0;
        o_cmd   <= ~o_cmd;
    endtask : send
endmodule : net_master_model

// [tb/tb_top.sv]
`timescale 1ns/10ps
`include "opmode_defs.svh"

module tb_top;
    import opmode_pkg::*;

    logic               clk, srst, net_valid, il_asg, os_asg, running, pwr, p_sel, p_ext, stop_all, pf_wr, wr_en;
    logic [2:0]         p_data, sel_init, mode_sel, refusals;
    term_pins_t         pins;
    net_cmd_t           net_cmd;
    mode_t              mode;
    logic               run_fwd, run_rev, ostop, wr_ok, wr_rej, refused;
    logic [`FREQ_W-1:0] freq_cmd, panel_freq;
    freq_in_t           freq_ext;
    int                 errors, comparisons;

    drive_operation_mode_select u_drive_operation_mode_select (
        .i_clk(clk), .i_srst(srst), .i_pins(pins), .i_freq_ext(freq_ext), .i_panel_freq(panel_freq),
        .i_panel_freq_wr(pf_wr), .i_net_cmd_valid(net_valid), .i_net_cmd(net_cmd),
        .i_motor_running(running), .i_mode_sel_init(sel_init), .i_interlock_assigned(il_asg),
        .i_ostop_assigned(os_asg), .i_stop_key_all(stop_all), .i_param_wr(pwr),
        .i_param_is_mode_sel(p_sel), .i_param_data(p_data), .i_param_ext_writable(p_ext),
        .i_param_write_enabled(wr_en), .o_mode(mode), .o_mode_sel(mode_sel), .o_run_fwd(run_fwd),
        .o_run_rev(run_rev), .o_freq_cmd(freq_cmd), .o_output_stop(ostop), .o_param_wr_ok(wr_ok),
        .o_param_wr_rej(wr_rej), .o_switch_refused(refused));

    net_master_model u_net_master_model (
        .i_clk(clk), .o_valid(net_valid), .o_cmd(net_cmd),
        .o_interlock_assigned(il_asg), .o_ostop_assigned(os_asg));

    // ============================================================
    // Shared tasks.
    task automatic final_report();
        $display("errors=%0d comparisons=%0d", errors, comparisons);
        if (errors == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : final_report

    task automatic check_mode(input mode_t exp);
        comparisons++;
        if (mode !== exp)
        begin
            errors++;
            $display("BAD t=%0t exp=%h got=%h", $time, exp, mode);
        end
    endtask : check_mode

    task automatic check_val(input logic [2:0] exp, input logic [2:0] got);
        comparisons++;
        if (got !== exp)
        begin
            errors++;
            $display("BAD t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask : check_val

    task automatic check_freq(input logic [`FREQ_W-1:0] exp);
        comparisons++;
        if (freq_cmd !== exp)
        begin
            errors++;
            $display("BAD t=%0t exp=%h got=%h", $time, exp, freq_cmd);
        end
    endtask : check_freq

    // Refusal pulses stand one cycle only, so they are counted at the edge that ends them.
    always @(posedge clk)
    begin
        if (srst)
            refusals <= 3'h0;
        else if (refused !== 1'b0)
            refusals <= refusals + 3'h1;
    end

    task automatic cycles(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cycles

    // Pins cross a three-stage synchroniser and filter, so each change is given eight cycles.
    task automatic set_pin(input int idx, input logic v);
        @(posedge clk);
        pins[idx] <= v;
        cycles(8);
    endtask : set_pin

    task automatic key(input int idx);
        set_pin(idx, 1'b1);
        set_pin(idx, 1'b0);
    endtask : key

    task automatic param_wr(input logic sel, input logic [2:0] d, input logic ext, input logic [2:0] exp);
        @(posedge clk);
        pwr    <= 1'b1;
        p_sel  <= sel;
        p_data <= d;
        p_ext  <= ext;
        @(posedge clk);
        pwr <= 1'b0;
        #1;
        check_val(exp, {1'b0, wr_ok, wr_rej});
        cycles(2);
    endtask : param_wr

    task automatic set_run(input logic v);
        @(posedge clk);
        running <= v;
    endtask : set_run

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial
    begin
        #100000;
        errors++;
        final_report();
    end

    // ============================================================
    // Main sequence.
    initial
    begin
        srst       = 1'b1;
        running    = 1'b0;
        pwr        = 1'b0;
        p_sel      = 1'b0;
        p_data     = 3'h0;
        p_ext      = 1'b0;
        wr_en      = 1'b1;
        stop_all   = 1'b1;
        pf_wr      = 1'b0;
        sel_init   = `SEL_EXT_PANEL;
        panel_freq = 16'h0050;
        freq_ext = '{16'h0100, 16'h0200, 16'h0300, 16'h0400};
        pins = '0;
        pins.panel_interlock_input = 1'b1;
        errors = 0;
        comparisons = 0;
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        cycles(3);
        check_mode(MODE_EXTERNAL);
        check_val(`SEL_EXT_PANEL, mode_sel);
        check_freq(16'h0100);
        set_pin(11, 1'b1);
        check_val(3'h1, {1'b0, run_rev, run_fwd});
        key(2);
        check_val(3'h0, {1'b0, run_rev, run_fwd});
        set_pin(11, 1'b0);
        param_wr(1'b0, 3'h0, 1'b0, 3'h1);
        param_wr(1'b0, 3'h0, 1'b1, 3'h2);
        key(1);
        check_mode(MODE_PANEL_UNIT);
        check_freq(16'h0100);
        u_net_master_model.send(1'b1, 1'b0);
        cycles(2);
        check_mode(MODE_NETWORK);
        @(posedge clk);
        freq_ext.analog2 <= 16'h0110;
        cycles(2);
        check_freq(16'h0100);
        u_net_master_model.send(1'b0, 1'b1);
        cycles(2);
        check_mode(MODE_EXTERNAL);
        check_freq(16'h0110);
        param_wr(1'b1, `SEL_EXT_ONLY, 1'b0, 3'h2);
        key(1);
        check_mode(MODE_EXTERNAL);
        check_val(3'h1, refusals);
        set_run(1'b1);
        param_wr(1'b1, `SEL_PANEL_ONLY, 1'b0, 3'h1);
        set_run(1'b0);
        param_wr(1'b1, `SEL_PANEL_ONLY, 1'b0, 3'h2);
        check_mode(MODE_PANEL_UNIT);
        check_freq(16'h0110);
        u_net_master_model.send(1'b1, 1'b0);
        cycles(2);
        check_mode(MODE_PANEL_UNIT);
        check_val(3'h2, refusals);
        param_wr(1'b1, `SEL_COMBINED1, 1'b0, 3'h2);
        check_mode(MODE_COMBINED1);
        @(posedge clk);
        pf_wr <= 1'b1;
        @(posedge clk);
        pf_wr <= 1'b0;
        cycles(2);
        check_freq(16'h0050);
        set_pin(11, 1'b1);
        check_val(3'h1, {1'b0, run_rev, run_fwd});
        set_pin(11, 1'b0);
        set_pin(7, 1'b1);
        check_freq(16'h0300);
        set_pin(9, 1'b1);
        check_freq(16'h0300);
        set_pin(7, 1'b0);
        check_freq(16'h0200);
        set_pin(9, 1'b0);
        param_wr(1'b1, `SEL_COMBINED2, 1'b0, 3'h2);
        check_mode(MODE_COMBINED2);
        check_freq(16'h0110);
        key(4);
        check_val(3'h1, {1'b0, run_rev, run_fwd});
        key(2);
        check_val(3'h0, {1'b0, run_rev, run_fwd});
        param_wr(1'b1, `SEL_INTERLOCK, 1'b0, 3'h2);
        check_val(3'h1, {2'b00, ostop});
        key(1);
        check_mode(MODE_PANEL_UNIT);
        param_wr(1'b0, 3'h0, 1'b0, 3'h2);
        @(posedge clk);
        wr_en <= 1'b0;
        param_wr(1'b0, 3'h0, 1'b0, 3'h1);
        @(posedge clk);
        wr_en <= 1'b1;
        set_pin(6, 1'b0);
        check_mode(MODE_EXTERNAL);
        check_val(3'h0, {2'b00, ostop});
        key(1);
        check_mode(MODE_EXTERNAL);
        check_val(3'h3, refusals);
        param_wr(1'b0, 3'h0, 1'b1, 3'h1);
        param_wr(1'b1, `SEL_INTERLOCK, 1'b0, 3'h2);
        set_pin(6, 1'b1);
        key(1);
        check_mode(MODE_PANEL_UNIT);
        u_net_master_model.assign_terminals(1'b0, 1'b1);
        cycles(3);
        check_mode(MODE_EXTERNAL);
        set_pin(5, 1'b1);
        check_val(3'h1, {2'b00, ostop});
        set_pin(5, 1'b0);
        u_net_master_model.assign_terminals(1'b1, 1'b1);
        param_wr(1'b1, `SEL_SWITCHOVER, 1'b0, 3'h2);
        set_run(1'b1);
        key(1);
        check_mode(MODE_PANEL_UNIT);
        check_freq(16'h0110);
        @(posedge clk);
        freq_ext.analog2 <= 16'h0120;
        key(0);
        check_mode(MODE_EXTERNAL);
        check_freq(16'h0120);
        u_net_master_model.send(1'b1, 1'b0);
        @(posedge clk);
        freq_ext.analog2 <= 16'h0130;
        cycles(2);
        check_mode(MODE_NETWORK);
        check_freq(16'h0120);
        key(1);
        check_mode(MODE_PANEL_UNIT);
        check_freq(16'h0120);
        @(posedge clk);
        srst     <= 1'b1;
        running  <= 1'b0;
        sel_init <= `SEL_PANEL_ONLY;
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        cycles(3);
        check_mode(MODE_PANEL_UNIT);
        check_val(`SEL_PANEL_ONLY, mode_sel);
        check_freq(16'h0000);
        final_report();
    end
endmodule : tb_top
